/* core/rfmd_core.sv */
// rf framing mode and antenna driver control with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module rfmd_core #(
  parameter logic REVISION_TWO = 1'b1
) (
  input wire logic CLK, // system clock, 50 MHz
  input wire logic ARST_N, // async reset, active low
  input wire logic CE, // clock enable, freezes all state when low
  input wire logic [7:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [7:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  input wire logic CARRIER, // 13.56 MHz carrier sampled
  input wire logic TX_DATA, // encoder envelope, high = modulate
  input wire logic MOD_PIN, // envelope from external modulation pin
  input wire logic TX_FRAME_END, // pulse: last data bit sent
  input wire logic RX_BIT, // pulse: one bit received
  input wire logic RX_FRAME_END, // pulse: received stream ended
  input wire logic CRC_GOOD, // crc coprocessor status
  input wire logic [7:0] ERROR_FLAGS, // current error flags register
  output logic ANTENNA_OUTPUT_A, // antenna driver a level
  output logic ANTENNA_OUTPUT_B, // antenna driver b level
  output logic SEND_CRC_APPEND, // append crc to sent frame
  output logic [2:0] SEND_BIT_RATE, // transmit rate code
  output logic RECV_CRC_CHECK, // check crc on received frame
  output logic [2:0] RECV_BIT_RATE, // receive rate code
  output logic [15:0] CRC_PRESET, // automatic crc preset
  output logic RECEIVER_ON, // receiver active
  output logic FIFO_PUSH, // pulse: push error byte to fifo
  output logic [7:0] FIFO_DATA, // byte pushed to fifo
  output logic SHORT_DROP // pulse: short stream discarded
);
  logic [7:0] tx_mode;
  logic [7:0] rx_mode;
  logic [7:0] tx_ctrl;
  logic [7:0] select;
  logic [3:0] command_register;
  logic [7:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_have;
  logic [2:0] bit_count;
  logic crc_pending;
  rfmd_pkg::rfmd_rx_state_t rx_state;
  rfmd_pkg::rfmd_rx_state_t next_rx_state;
  logic do_write;
  logic cmd_write;
  logic [3:0] new_cmd;
  logic multi;
  logic recv_cmd;
  logic short_stream;
  logic [7:0] err_byte;
  logic [31:0] read_word;
  logic read_ok;
  logic write_ok;
  logic next_a;
  logic next_b;
  logic envelope;

  assign do_write = aw_have && w_have && !S_AXI_BVALID;
  assign cmd_write = do_write && w_strb[0] && aw_addr == {rfmd_pkg::IDX_COMMAND[5:0], 2'b00};
  assign new_cmd = w_data[3:0] & rfmd_pkg::COMMAND_MASK[3:0];
  assign multi = rx_mode[rfmd_pkg::MULTI_BIT];
  assign recv_cmd = command_register == rfmd_pkg::CMD_RECEIVE
      || command_register == rfmd_pkg::CMD_TRANSCEIVE;
  assign short_stream = {1'b0, bit_count} < 4'(rfmd_pkg::MIN_VALID_BITS);

  // word address check: index times four
  always_comb begin
    write_ok = 1'b1;
    if (aw_addr == {rfmd_pkg::IDX_TX_MODE[5:0], 2'b00}) begin
      write_ok = 1'b1;
    end else if (aw_addr == {rfmd_pkg::IDX_RX_MODE[5:0], 2'b00}) begin
      write_ok = 1'b1;
    end else if (aw_addr == {rfmd_pkg::IDX_TX_CTRL[5:0], 2'b00}) begin
      write_ok = 1'b1;
    end else if (aw_addr == {rfmd_pkg::IDX_SELECT[5:0], 2'b00}) begin
      write_ok = 1'b1;
    end else if (aw_addr == {rfmd_pkg::IDX_COMMAND[5:0], 2'b00}) begin
      write_ok = 1'b1;
    end else begin
      write_ok = 1'b0;
    end
  end

  // axi write channels, taken in either order
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_have <= 1'b0;
      aw_addr <= 8'h00;
      w_have <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= rfmd_pkg::RESP_OKAY;
    end else if (CE) begin
      S_AXI_AWREADY <= !aw_have && !S_AXI_AWREADY;
      S_AXI_WREADY <= !w_have && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= write_ok ? rfmd_pkg::RESP_OKAY : rfmd_pkg::RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_have <= 1'b0;
        w_have <= 1'b0;
      end
    end
  end

  // register storage, reserved bits masked off
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_mode <= rfmd_pkg::TX_MODE_RESET;
      rx_mode <= rfmd_pkg::RX_MODE_RESET;
      tx_ctrl <= rfmd_pkg::TX_CTRL_RESET;
      select <= rfmd_pkg::SELECT_RESET;
    end else if (CE && do_write && w_strb[0]) begin
      if (aw_addr == {rfmd_pkg::IDX_TX_MODE[5:0], 2'b00}) begin
        tx_mode <= w_data[7:0] & rfmd_pkg::TX_MODE_MASK;
      end else if (aw_addr == {rfmd_pkg::IDX_RX_MODE[5:0], 2'b00}) begin
        rx_mode <= w_data[7:0] & rfmd_pkg::RX_MODE_MASK;
      end else if (aw_addr == {rfmd_pkg::IDX_TX_CTRL[5:0], 2'b00}) begin
        tx_ctrl <= w_data[7:0] & rfmd_pkg::TX_CTRL_MASK;
      end else if (aw_addr == {rfmd_pkg::IDX_SELECT[5:0], 2'b00}) begin
        select <= w_data[7:0] & rfmd_pkg::SELECT_MASK;
      end
    end
  end

  // command register; a receive command clears back to idle when done
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      command_register <= rfmd_pkg::CMD_IDLE;
    end else if (CE) begin
      if (cmd_write) begin
        command_register <= new_cmd;
      end else if (rx_state == rfmd_pkg::RX_ACTIVE && next_rx_state
          == rfmd_pkg::RX_IDLE) begin
        command_register <= rfmd_pkg::CMD_IDLE;
      end
    end
  end

  // read channel: one cycle to rvalid after the address is taken
  always_comb begin
    read_word = 32'h0;
    read_ok = 1'b1;
    if (S_AXI_ARADDR == {rfmd_pkg::IDX_TX_MODE[5:0], 2'b00}) begin
      read_word[7:0] = tx_mode;
    end else if (S_AXI_ARADDR == {rfmd_pkg::IDX_RX_MODE[5:0], 2'b00}) begin
      read_word[7:0] = rx_mode;
    end else if (S_AXI_ARADDR == {rfmd_pkg::IDX_TX_CTRL[5:0], 2'b00}) begin
      read_word[7:0] = tx_ctrl;
    end else if (S_AXI_ARADDR == {rfmd_pkg::IDX_SELECT[5:0], 2'b00}) begin
      read_word[7:0] = select;
    end else if (S_AXI_ARADDR == {rfmd_pkg::IDX_COMMAND[5:0], 2'b00}) begin
      read_word[3:0] = command_register;
    end else if (S_AXI_ARADDR == {rfmd_pkg::IDX_ERROR[5:0], 2'b00}) begin
      read_word[7:0] = ERROR_FLAGS;
    end else if (S_AXI_ARADDR == {rfmd_pkg::IDX_STATUS[5:0], 2'b00}) begin
      read_word[1:0] = rx_state;
      read_word[2] = RECEIVER_ON;
    end else begin
      read_ok = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= rfmd_pkg::RESP_OKAY;
    end else if (CE) begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      // data latched with rvalid so any master may take it at once
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= read_word;
        S_AXI_RRESP <= read_ok ? rfmd_pkg::RESP_OKAY : rfmd_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // framing outputs
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SEND_CRC_APPEND <= 1'b0;
      SEND_BIT_RATE <= rfmd_pkg::RATE_106;
      RECV_CRC_CHECK <= 1'b0;
      RECV_BIT_RATE <= rfmd_pkg::RATE_106;
      CRC_PRESET <= rfmd_pkg::CRC_PRESET_106;
    end else if (CE) begin
      // crc forced on above 106 kBd so a stale clear cannot break framing
      SEND_CRC_APPEND <= tx_mode[rfmd_pkg::CRC_EN_BIT]
          || tx_mode[rfmd_pkg::RATE_HI:rfmd_pkg::RATE_LO]
          != rfmd_pkg::RATE_106;
      RECV_CRC_CHECK <= rx_mode[rfmd_pkg::CRC_EN_BIT]
          || rx_mode[rfmd_pkg::RATE_HI:rfmd_pkg::RATE_LO]
          != rfmd_pkg::RATE_106;
      // reserved rate codes hold the last legal rate
      if (tx_mode[rfmd_pkg::RATE_HI:rfmd_pkg::RATE_LO] <= rfmd_pkg::RATE_848) begin
        SEND_BIT_RATE <= tx_mode[rfmd_pkg::RATE_HI:rfmd_pkg::RATE_LO];
      end
      if (rx_mode[rfmd_pkg::RATE_HI:rfmd_pkg::RATE_LO] <= rfmd_pkg::RATE_848) begin
        RECV_BIT_RATE <= rx_mode[rfmd_pkg::RATE_HI:rfmd_pkg::RATE_LO];
      end
      // preset follows the rate in use, so a reserved code keeps it too
      CRC_PRESET <= (tx_mode[rfmd_pkg::RATE_HI:rfmd_pkg::RATE_LO]
          == rfmd_pkg::RATE_106
          || (tx_mode[rfmd_pkg::RATE_HI:rfmd_pkg::RATE_LO] > rfmd_pkg::RATE_848
          && SEND_BIT_RATE == rfmd_pkg::RATE_106))
          ? rfmd_pkg::CRC_PRESET_106 : rfmd_pkg::CRC_PRESET_HI;
    end
  end

  // error byte: revision picks crc-good or crc-error polarity
  always_comb begin
    err_byte = ERROR_FLAGS;
    err_byte[rfmd_pkg::ERR_CRC_BIT] = REVISION_TWO ? CRC_GOOD
        : !CRC_GOOD;
  end

  // receiver sequencing
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      rfmd_pkg::RX_IDLE: begin
        if (cmd_write && (new_cmd == rfmd_pkg::CMD_RECEIVE
            || new_cmd == rfmd_pkg::CMD_TRANSCEIVE)) begin
          next_rx_state = rfmd_pkg::RX_ACTIVE;
        end
      end
      rfmd_pkg::RX_ACTIVE: begin
        if ((cmd_write && new_cmd != rfmd_pkg::CMD_RECEIVE) || !recv_cmd) begin
          next_rx_state = rfmd_pkg::RX_IDLE;
        end else if (RX_FRAME_END) begin
          if (short_stream && rx_mode[rfmd_pkg::NO_ERR_BIT]) begin
            next_rx_state = rfmd_pkg::RX_ACTIVE;
          end else if (multi) begin
            next_rx_state = rfmd_pkg::RX_APPEND;
          end else begin
            next_rx_state = rfmd_pkg::RX_IDLE;
          end
        end else if (!multi && crc_pending) begin
          next_rx_state = rfmd_pkg::RX_IDLE;
        end
      end
      rfmd_pkg::RX_APPEND: begin
        next_rx_state = rfmd_pkg::RX_ACTIVE;
      end
      default: begin
        next_rx_state = rfmd_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_state <= rfmd_pkg::RX_IDLE;
      bit_count <= 3'h0;
      crc_pending <= 1'b0;
      RECEIVER_ON <= 1'b0;
      FIFO_PUSH <= 1'b0;
      FIFO_DATA <= 8'h00;
      SHORT_DROP <= 1'b0;
    end else if (CE) begin
      rx_state <= next_rx_state;
      RECEIVER_ON <= next_rx_state != rfmd_pkg::RX_IDLE;
      // multi-frame cleared mid-run ends reception at the next cycle
      if (next_rx_state == rfmd_pkg::RX_IDLE) begin
        crc_pending <= 1'b0;
      end else if (multi) begin
        crc_pending <= 1'b1;
      end
      FIFO_PUSH <= 1'b0;
      SHORT_DROP <= 1'b0;
      if (RX_FRAME_END || rx_state == rfmd_pkg::RX_IDLE) begin
        bit_count <= 3'h0;
      end else if (RX_BIT && short_stream) begin
        bit_count <= bit_count + 3'h1;
      end
      if (rx_state == rfmd_pkg::RX_ACTIVE && RX_FRAME_END && short_stream
          && rx_mode[rfmd_pkg::NO_ERR_BIT]) begin
        SHORT_DROP <= 1'b1;
      end
      if (next_rx_state == rfmd_pkg::RX_APPEND) begin
        FIFO_PUSH <= 1'b1;
        FIFO_DATA <= err_byte;
      end
    end
  end

  // antenna drivers
  always_comb begin
    envelope = 1'b0;
    case (select[rfmd_pkg::SRC_HI:rfmd_pkg::SRC_LO])
      rfmd_pkg::SRC_ENCODER: envelope = TX_DATA ^ tx_mode[rfmd_pkg::INV_MOD_BIT];
      rfmd_pkg::SRC_PIN: envelope = MOD_PIN;
      default: envelope = 1'b0;
    endcase
    // modulation gaps the carrier; constant high keeps carrier only
    next_a = tx_ctrl[rfmd_pkg::A_EN_BIT] ? ((CARRIER && !envelope)
        ^ tx_ctrl[rfmd_pkg::A_INV_ON_BIT])
        : tx_ctrl[rfmd_pkg::A_INV_OFF_BIT];
    next_b = tx_ctrl[rfmd_pkg::B_EN_BIT] ? ((CARRIER
        && (tx_ctrl[rfmd_pkg::B_CW_BIT] || !envelope))
        ^ tx_ctrl[rfmd_pkg::B_INV_ON_BIT])
        : tx_ctrl[rfmd_pkg::B_INV_OFF_BIT];
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ANTENNA_OUTPUT_A <= 1'b0;
      ANTENNA_OUTPUT_B <= 1'b0;
    end else if (CE) begin
      ANTENNA_OUTPUT_A <= next_a;
      ANTENNA_OUTPUT_B <= next_b;
    end
  end
endmodule
`default_nettype wire

/* core/rfmd_pkg.sv */
// register map, field positions and reset values of the rf mode block
package rfmd_pkg;
  localparam logic [7:0] IDX_TX_MODE = 8'h12;
  localparam logic [7:0] IDX_RX_MODE = 8'h13;
  localparam logic [7:0] IDX_TX_CTRL = 8'h14;
  localparam logic [7:0] IDX_SELECT = 8'h16;
  localparam logic [7:0] IDX_COMMAND = 8'h01;
  localparam logic [7:0] IDX_ERROR = 8'h06;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] TX_MODE_RESET = 8'h00;
  localparam logic [7:0] RX_MODE_RESET = 8'h00;
  localparam logic [7:0] TX_CTRL_RESET = 8'h80;
  localparam logic [7:0] SELECT_RESET = 8'h10;
  localparam logic [7:0] TX_MODE_MASK = 8'hf8;
  localparam logic [7:0] RX_MODE_MASK = 8'hfc;
  localparam logic [7:0] TX_CTRL_MASK = 8'hfb;
  localparam logic [7:0] SELECT_MASK = 8'h30;
  localparam logic [7:0] COMMAND_MASK = 8'h0f;
  localparam int CRC_EN_BIT = 7;
  localparam int RATE_HI = 6;
  localparam int RATE_LO = 4;
  localparam int INV_MOD_BIT = 3;
  localparam int NO_ERR_BIT = 3;
  localparam int MULTI_BIT = 2;
  localparam int B_INV_ON_BIT = 7;
  localparam int A_INV_ON_BIT = 6;
  localparam int B_INV_OFF_BIT = 5;
  localparam int A_INV_OFF_BIT = 4;
  localparam int B_CW_BIT = 3;
  localparam int B_EN_BIT = 1;
  localparam int A_EN_BIT = 0;
  localparam int SRC_HI = 5;
  localparam int SRC_LO = 4;
  localparam int ERR_CRC_BIT = 2;
  localparam int MIN_VALID_BITS = 4;
  localparam logic [2:0] RATE_106 = 3'h0;
  localparam logic [2:0] RATE_848 = 3'h3;
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_RECEIVE = 4'h8;
  localparam logic [3:0] CMD_TRANSCEIVE = 4'hc;
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_ENCODER = 2'h1;
  localparam logic [1:0] SRC_PIN = 2'h2;
  localparam logic [1:0] SRC_HIGH = 2'h3;
  localparam logic [15:0] CRC_PRESET_106 = 16'h6363;
  localparam logic [15:0] CRC_PRESET_HI = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ACTIVE = 2'b01,
    RX_APPEND = 2'b10
  } rfmd_rx_state_t;
endpackage

/* testbench/rf_mode_and_antenna_driver_ctrl_tb.sv */
// self-checking bench: register model, antenna levels and reception
`timescale 1ns/1ps
`default_nettype none
module rf_mode_and_antenna_driver_ctrl_tb;
  localparam logic [7:0] A_TXM = rfmd_pkg::IDX_TX_MODE << 2;
  localparam logic [7:0] A_RXM = rfmd_pkg::IDX_RX_MODE << 2;
  localparam logic [7:0] A_CTL = rfmd_pkg::IDX_TX_CTRL << 2;
  localparam logic [7:0] A_CMD = rfmd_pkg::IDX_COMMAND << 2;
  localparam logic [7:0] A_SEL = rfmd_pkg::IDX_SELECT << 2;
  localparam logic [1:0] OK = rfmd_pkg::RESP_OKAY;
  logic clk = 1'b0, arst_n = 1'b0, txd = 1'b0, modp = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, carrier, rx_bit, rx_end;
  logic crc_good, ant_a, ant_b, s_crc, r_crc, rx_on, push, drop, car_d, env_d;
  logic [1:0] bresp, rresp, rr, e;
  logic [2:0] s_rate, r_rate;
  logic [7:0] err_flags, fdata, txm, rxm, ctl, sel, d;
  logic pin_d, ce = 1'b1;
  logic [15:0] preset;
  logic [31:0] rdata, rv, qv;
  logic [31:0] exp_q[$];
  logic [3:0] cmds[2] = '{rfmd_pkg::CMD_RECEIVE, rfmd_pkg::CMD_TRANSCEIVE};
  int miscompares = 0, n_tests = 0, drops = 0;
  always #10 clk = ~clk;
  rfmd_core #(.REVISION_TWO(1'b1)) dut_u (
    .CLK(clk), .ARST_N(arst_n), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CARRIER(carrier),
    .TX_DATA(txd), .MOD_PIN(modp), .TX_FRAME_END(1'b0), .RX_BIT(rx_bit),
    .RX_FRAME_END(rx_end), .CRC_GOOD(crc_good), .ERROR_FLAGS(err_flags),
    .ANTENNA_OUTPUT_A(ant_a), .ANTENNA_OUTPUT_B(ant_b),
    .SEND_CRC_APPEND(s_crc), .SEND_BIT_RATE(s_rate), .RECV_CRC_CHECK(r_crc),
    .RECV_BIT_RATE(r_rate), .CRC_PRESET(preset), .RECEIVER_ON(rx_on),
    .FIFO_PUSH(push), .FIFO_DATA(fdata), .SHORT_DROP(drop));
  rfmd_card card_u (.clk(clk), .carrier(carrier), .rx_bit(rx_bit),
    .rx_end(rx_end), .crc_good(crc_good), .err_flags(err_flags));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    logic aw, w;
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    {awaddr, wdata, wstrb} <= {a, 24'h0, v, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    forever begin
      @(posedge clk);
      if (aw && awready) aw = 1'b0;
      if (w && wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar;
    @(posedge clk);
    ar = 1'b1;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    forever begin
      @(posedge clk);
      if (ar && arready) ar = 1'b0;
      arvalid <= ar;
      if (rvalid === 1'b1) break;
    end
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] v);
    rd(a);
    chk(rv, {24'h0, v});
    chk(32'(rr), 32'(OK));
  endtask
  // random write, reserved bits random too; model keeps only defined bits
  task automatic setr(input logic [7:0] a, input logic [7:0] m,
                      input logic lim, output logic [7:0] r);
    d = 8'($urandom);
    if (lim) d[6:4] = 3'($urandom_range(3, 0));
    if (lim && d[6:4] != 3'h0) d[7] = 1'b1;
    if (lim && d[6:4] == 3'h0) d[2] = 1'b0;
    wr(a, d, OK);
    r = d & m;
    rchk(a, r);
  endtask
  task automatic outs;
    chk(32'(s_rate), 32'(txm[6:4]));
    chk(32'(s_crc), 32'(txm[7] | (txm[6:4] != 3'h0)));
    chk(32'(r_rate), 32'(rxm[6:4]));
    chk(32'(r_crc), 32'(rxm[7] | (rxm[6:4] != 3'h0)));
    chk(32'(preset), txm[6:4] == 3'h0 ? 32'h6363 : 32'h0);
  endtask
  task automatic wait_on(input logic v);
    for (int k = 0; k < 8 && rx_on !== v; k++) @(posedge clk);
    chk(32'(rx_on), 32'(v));
  endtask
  function automatic logic [1:0] ant(input logic c, input logic en,
                                     input logic p);
    logic m;
    logic v;
    v = sel[5:4] == 2'h1 ? en ^ txm[3] : sel[5:4] == 2'h2 ? p : 1'b0;
    m = c & ~v;
    ant[0] = ctl[0] ? m ^ ctl[6] : ctl[4];
    ant[1] = ctl[1] ? (ctl[3] ? c : m) ^ ctl[7] : ctl[5];
  endfunction
  always @(posedge clk) begin
    car_d <= carrier;
    env_d <= txd;
    pin_d <= modp;
    if (drop === 1'b1) drops <= drops + 1;
    if (push === 1'b1) begin
      qv = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      chk({24'h0, fdata}, qv);
    end
  end
  initial begin
    void'($urandom(13));
    {txm, rxm, ctl, sel} = {8'h00, 8'h00, 8'h80, 8'h10};
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rchk(A_RXM, 8'h00);
    rchk(A_CTL, 8'h80);
    rchk(A_TXM, 8'h00);
    outs();
    wr(8'h3c, 8'hff, rfmd_pkg::RESP_SLVERR);
    rd(8'h3c);
    chk(32'(rr), 32'(rfmd_pkg::RESP_SLVERR));
    repeat (16) begin
      setr(A_TXM, rfmd_pkg::TX_MODE_MASK, 1'b1, txm);
      setr(A_RXM, rfmd_pkg::RX_MODE_MASK, 1'b1, rxm);
      setr(A_CTL, rfmd_pkg::TX_CTRL_MASK, 1'b0, ctl);
      setr(A_SEL, rfmd_pkg::SELECT_MASK, 1'b0, sel);
      outs();
      repeat (6) begin
        @(posedge clk);
        e = ant(car_d, env_d, pin_d);
        chk(32'(ant_a), 32'(e[0]));
        chk(32'(ant_b), 32'(e[1]));
        txd <= 1'($urandom);
        modp <= 1'($urandom);
      end
    end
    // clock enable low must hold the antenna levels
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    rv = {30'h0, ant_a, ant_b};
    repeat (4) begin
      @(posedge clk);
      txd <= ~txd;
      chk({30'h0, ant_a, ant_b}, rv);
    end
    ce <= 1'b1;
    wr(A_TXM, {1'b1, 3'h5, txm[3:0]}, OK);
    repeat (2) @(posedge clk);
    chk(32'(s_rate), 32'(txm[6:4]));
    chk(32'(preset), txm[6:4] == 3'h0 ? 32'h6363 : 32'h0);
    wr(A_RXM, 8'h90, OK);
    foreach (cmds[i]) begin
      wr(A_CMD, {4'h0, cmds[i]}, OK);
      wait_on(1'b1);
      card_u.frame(8, 8'h00, 1'b1);
      wait_on(1'b0);
      rchk(A_CMD, 8'h00);
    end
    wr(A_RXM, 8'hac, OK);
    foreach (cmds[i]) begin
      wr(A_CMD, {4'h0, cmds[i]}, OK);
      wait_on(1'b1);
      repeat (2) begin
        {d, e[0]} = 9'($urandom);
        exp_q.push_back({24'h0, d[7:3], e[0], d[1:0]});
        card_u.frame(9, d, e[0]);
      end
      card_u.frame(2, 8'h00, 1'b0);
      repeat (3) @(posedge clk);
      chk(32'(drops), 32'(i + 1));
      chk(32'(rx_on), 32'h1);
      if (i == 0) wr(A_CMD, {4'h0, rfmd_pkg::CMD_IDLE}, OK);
      else begin
        wr(A_CMD, {4'h0, rfmd_pkg::CMD_RECEIVE}, OK);
        chk(32'(rx_on), 32'h1);
        wr(A_RXM, 8'ha8, OK);
      end
      wait_on(1'b0);
    end
    chk(32'(exp_q.size()), 32'h0);
    wrap_up();
  end
  // whole run needs under a thousand cycles; hang guard at 20000
  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire

/* testbench/rfmd_card.sv */
// card side model: sampled carrier and received stream events
`timescale 1ns/1ps
`default_nettype none
module rfmd_card (
  input wire logic clk, // system clock
  output logic carrier, // sampled carrier
  output logic rx_bit, // pulse per received bit
  output logic rx_end, // pulse at stream end
  output logic crc_good, // crc status of last stream
  output logic [7:0] err_flags // error flags of last stream
);
  initial begin
    carrier = 1'b0;
    rx_bit = 1'b0;
    rx_end = 1'b0;
    crc_good = 1'b0;
    err_flags = 8'h00;
  end
  // carrier is not locked to clk, so its sampled level is modelled as random
  always @(posedge clk) carrier <= 1'($urandom);
  task automatic frame(input int nbits, input logic [7:0] e, input logic c);
    repeat (nbits) begin
      @(posedge clk);
      rx_bit <= 1'b1;
      @(posedge clk);
      rx_bit <= 1'b0;
    end
    @(posedge clk);
    err_flags <= e;
    crc_good <= c;
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/rfmd_sva.sv */
// assertion checker for the rf mode block, bound to its top ports
`timescale 1ns/1ps
`default_nettype none
module rfmd_sva #(
  parameter logic REVISION_TWO = 1'b1
) (
  input wire logic CLK, // clock
  input wire logic ARST_N, // reset, active low
  input wire logic RX_FRAME_END, // stream end
  input wire logic CRC_GOOD, // crc status
  input wire logic [7:0] ERROR_FLAGS, // error flags
  input wire logic SEND_CRC_APPEND, // tx crc
  input wire logic [2:0] SEND_BIT_RATE, // tx rate
  input wire logic RECV_CRC_CHECK, // rx crc
  input wire logic [2:0] RECV_BIT_RATE, // rx rate
  input wire logic [15:0] CRC_PRESET, // crc preset
  input wire logic RECEIVER_ON, // receiver on
  input wire logic FIFO_PUSH, // push pulse
  input wire logic [7:0] FIFO_DATA, // pushed byte
  input wire logic SHORT_DROP // drop pulse
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_one_shot;
    ##1 !FIFO_PUSH;
  endsequence
  sequence s_from_end;
    $past(RX_FRAME_END) && RECEIVER_ON;
  endsequence
  preset_auto_a: assert property (
    CRC_PRESET == (SEND_BIT_RATE == 3'h0 ? 16'h6363 : 16'h0000))
    else $error("crc preset does not follow rate");
  tx_crc_forced_a: assert property (
    SEND_BIT_RATE != 3'h0 |-> SEND_CRC_APPEND)
    else $error("tx crc off above base rate");
  rx_crc_forced_a: assert property (
    RECV_BIT_RATE != 3'h0 |-> RECV_CRC_CHECK)
    else $error("rx crc off above base rate");
  tx_rate_legal_a: assert property (SEND_BIT_RATE <= 3'h3)
    else $error("tx rate code reserved");
  rx_rate_legal_a: assert property (RECV_BIT_RATE <= 3'h3)
    else $error("rx rate code reserved");
  push_single_a: assert property (FIFO_PUSH |-> s_one_shot)
    else $error("push longer than one cycle");
  push_cause_a: assert property (FIFO_PUSH |-> s_from_end)
    else $error("push without stream end or receiver off");
  err_copy_a: assert property (
    FIFO_PUSH |-> (FIFO_DATA & 8'hfb) == ($past(ERROR_FLAGS) & 8'hfb))
    else $error("error byte not a copy");
  crc_flag_a: assert property (
    FIFO_PUSH |-> FIFO_DATA[2] == ($past(CRC_GOOD) ~^ REVISION_TWO))
    else $error("crc flag polarity wrong");
  drop_keeps_on_a: assert property (
    SHORT_DROP |-> RECEIVER_ON && !FIFO_PUSH)
    else $error("short stream ended reception");
endmodule
bind rfmd_core rfmd_sva #(.REVISION_TWO(REVISION_TWO)) sva_u (
  .CLK(CLK), .ARST_N(ARST_N), .RX_FRAME_END(RX_FRAME_END),
  .CRC_GOOD(CRC_GOOD), .ERROR_FLAGS(ERROR_FLAGS),
  .SEND_CRC_APPEND(SEND_CRC_APPEND), .SEND_BIT_RATE(SEND_BIT_RATE),
  .RECV_CRC_CHECK(RECV_CRC_CHECK), .RECV_BIT_RATE(RECV_BIT_RATE),
  .CRC_PRESET(CRC_PRESET), .RECEIVER_ON(RECEIVER_ON),
  .FIFO_PUSH(FIFO_PUSH), .FIFO_DATA(FIFO_DATA), .SHORT_DROP(SHORT_DROP)
);
`default_nettype wire
